//--- asp_pkg.sv
// Shared constants for the audio serial port: register map, field layout,
// reset values and timing counts.
// Assumes a 125 MHz system clock and an 8-bit external data memory bus.
package asp_pkg;

	// Register window within external data memory.
	localparam logic [15:0] ASP_ADDR_LO    = 16'hDF40;	// First decoded address.
	localparam logic [15:0] ASP_ADDR_HI    = 16'hDF48;	// Last decoded address.
	localparam logic [15:0] ASP_ADDR_CFG0  = 16'hDF40;	// Configuration register 0.
	localparam logic [15:0] ASP_ADDR_CFG1  = 16'hDF41;	// Configuration register 1.
	localparam logic [15:0] ASP_ADDR_DATL  = 16'hDF42;	// Data low byte.
	localparam logic [15:0] ASP_ADDR_DATH  = 16'hDF43;	// Data high byte.
	localparam logic [15:0] ASP_ADDR_STAT  = 16'hDF46;	// Status register.

	// Field positions of configuration register 0.
	localparam int ASP_BIT_TX_IRQ_EN  = 7;	// Transmit interrupt enable.
	localparam int ASP_BIT_RX_IRQ_EN  = 6;	// Receive interrupt enable.
	localparam int ASP_BIT_EXPAND     = 5;	// Mu-law expansion enable.
	localparam int ASP_BIT_COMPRESS   = 4;	// Mu-law compression enable.
	localparam int ASP_BIT_TX_MONO    = 3;	// Transmit mono.
	localparam int ASP_BIT_RX_MONO    = 2;	// Receive mono.
	localparam int ASP_BIT_MASTER     = 1;	// Master timing.
	localparam int ASP_BIT_ENABLE     = 0;	// Port enable.

	// Field layout of configuration register 1 and of the status register.
	localparam int ASP_WORDS_LSB      = 3;	// Word size minus one, bits 7:3.
	localparam int ASP_STAT_TX_EMPTY  = 0;	// Transmit buffer empty.
	localparam int ASP_STAT_RX_FULL   = 1;	// Receive buffer full.

	// Reset values: disabled, sixteen-bit stereo.
	localparam logic [7:0] ASP_CFG0_RESET = 8'h00;
	localparam logic [7:0] ASP_CFG1_RESET = 8'h78;

	// Timing: master serial clock for the reset sample rate.
	localparam int ASP_CLK_HZ      = 125000000;	// System clock rate.
	localparam int ASP_SAMPLE_HZ   = 44100;		// Reset sample rate.
	localparam int ASP_WORD_BITS   = 16;		// Reset word size.
	localparam int ASP_SCK_HALF    = ASP_CLK_HZ / (4 * ASP_WORD_BITS * ASP_SAMPLE_HZ);

	// Mu-law constants.
	localparam logic [15:0] ASP_MULAW_BIAS = 16'h0084;	// Encoding bias.
	localparam logic [15:0] ASP_MULAW_CLIP = 16'h7F7B;	// Largest magnitude.

endpackage : asp_pkg

//--- asp_mulaw.sv
// Combinational mu-law codec: one expander and one compressor.
// Assumes the caller registers the results.
`timescale 1ns/1ps
module asp_mulaw
(
	// Expansion path.
	input  wire logic [7:0]  expand_in,
	output logic      [15:0] expand_out,
	// Compression path.
	input  wire logic [15:0] compress_in,
	output logic      [7:0]  compress_out
);
	import asp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Expansion: invert, rebuild biased magnitude, remove bias, apply sign.
	logic [7:0]  inv;	// Inverted code byte.
	logic [15:0] mag;	// Biased magnitude.
	always_comb
	begin
		inv = ~expand_in;
		mag = ({8'h00, 1'b0, inv[3:0], 3'b000} + ASP_MULAW_BIAS) << inv[6:4];
		if (inv[7])
			expand_out = ASP_MULAW_BIAS - mag;	// Negative sample.
		else
			expand_out = mag - ASP_MULAW_BIAS;	// Positive sample.
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compression: clip magnitude, add bias, find segment, take four mantissa bits.
	logic [15:0] cmag;	// Magnitude being encoded.
	logic [2:0]  seg;	// Segment number.
	logic [15:0] shr;	// Magnitude shifted to the mantissa.
	always_comb
	begin
		cmag = compress_in[15] ? (16'h0000 - compress_in) : compress_in;
		if (cmag > ASP_MULAW_CLIP)
			cmag = ASP_MULAW_CLIP;	// Clip to avoid overflow of the bias add.
		cmag = cmag + ASP_MULAW_BIAS;
		seg = 3'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (cmag[i + 7])
				seg = i[2:0];	// Highest set bit wins.
		end
		// Widened so that segments five to seven do not wrap the shift amount.
		shr = cmag >> ({1'b0, seg} + 4'h3);
		compress_out = ~{compress_in[15], seg, shr[3:0]};
	end

endmodule : asp_mulaw

//--- asp_port.sv
// Audio serial port: control registers, mu-law unit and serial link logic.
// Assumes a byte-wide external data memory bus on ref_clk and a serial clock
// pad whose returned level (sck_in) is the clock of the link logic.
//
// Operation
// RULE_01: Decode registers from 0xDF40 through 0xDF48.
// RULE_02: Reset values give sixteen-bit stereo, 44.1 kHz.
// RULE_03: Port disabled after reset, enable bit zero.
// RULE_04: Expand high byte writes, or transmit data.
// RULE_05: Compress written word, or received samples.
// RULE_06: Transmit mono repeats sample in both channels.
// RULE_07: Receive mono discards right channel words.
// RULE_08: Master generates clock and word select.
// RULE_09: Disabled port still works as codec.
// RULE_10: Software sets only one codec bit.
// RULE_11: Standalone conversion completes one cycle after write.
// RULE_12: Interrupt requests gated by enable bits.
`timescale 1ns/1ps
module asp_port
#(
	parameter int SCK_HALF = asp_pkg::ASP_SCK_HALF	// Master half period in ref_clk cycles.
)
(
	// System clock, reset and enable.
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// External data memory bus.
	input  wire logic [15:0] xaddr,
	input  wire logic        xwr,
	input  wire logic        xrd,
	input  wire logic [7:0]  xwdata,
	output logic      [7:0]  xrdata,
	// Interrupt requests.
	output logic             tx_irq,
	output logic             rx_irq,
	// Serial clock pad.
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	// Word select pad.
	input  wire logic        ws_in,
	output logic             ws_out,
	output logic             ws_oe,
	// Serial data.
	input  wire logic        rx_sd,
	output logic             tx_sd
);
	import asp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register state in the system domain.
	logic [7:0]  audio_port_config0;	// Configuration register 0.
	logic [7:0]  audio_port_config1;	// Configuration register 1.
	logic [7:0]  audio_data_low;	// Data low byte.
	logic [7:0]  audio_data_high;	// Data high byte.
	logic        tx_empty;		// Transmit buffer may take a sample.
	logic        rx_full;		// Received sample waiting.
	logic        pend_wr;		// High byte written last cycle.
	logic [15:0] tx_hold;		// Sample offered to the link.
	logic        tx_req_tgl;	// Toggles when tx_hold is new.
	logic [2:0]  ack_s;		// Fetch toggle synchroniser and edge stage.
	logic [2:0]  rxt_s;		// Receive toggle synchroniser and edge stage.
	logic [15:0] exp_out;		// Expander result.
	logic [7:0]  cmp_out;		// Compressor result.
	logic [15:0] cmp_in;		// Compressor source.
	logic [15:0] rx_lbuf;		// Last received word, link domain.
	logic        rx_tgl;		// Toggles when rx_lbuf is new.
	logic        tx_ack_tgl;	// Toggles when a sample is fetched.

	wire enable   = audio_port_config0[ASP_BIT_ENABLE];
	wire expand   = audio_port_config0[ASP_BIT_EXPAND];
	wire compress = audio_port_config0[ASP_BIT_COMPRESS];
	wire in_range = (xaddr >= ASP_ADDR_LO) && (xaddr <= ASP_ADDR_HI);	// [RULE_01]
	wire wr_dath  = clk_en && xwr && (xaddr == ASP_ADDR_DATH);
	wire rd_dath  = clk_en && xrd && (xaddr == ASP_ADDR_DATH);
	wire fetched  = ack_s[2] ^ ack_s[1];	// Link took a sample.
	wire rx_new   = rxt_s[2] ^ rxt_s[1];	// Link delivered a word.

	// Compressor sees the written word when standalone, else the received one.
	assign cmp_in = enable ? rx_lbuf : {audio_data_high, audio_data_low};

	asp_mulaw u_mulaw
	(
		.expand_in    (audio_data_high),
		.expand_out   (exp_out),
		.compress_in  (cmp_in),
		.compress_out (cmp_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration writes; decode stays inside the port's window.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			audio_port_config0 <= ASP_CFG0_RESET;	// [RULE_03]
			audio_port_config1 <= ASP_CFG1_RESET;	// [RULE_02]
		end
		else if (clk_en && xwr && in_range)
		begin
			if (xaddr == ASP_ADDR_CFG0)
				audio_port_config0 <= xwdata;
			if (xaddr == ASP_ADDR_CFG1)
				audio_port_config1 <= xwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data registers: software writes, standalone conversion and received words.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			audio_data_low  <= 8'h00;
			audio_data_high <= 8'h00;
			pend_wr         <= 1'b0;
		end
		else if (clk_en)
		begin
			pend_wr <= wr_dath;
			if (xwr && (xaddr == ASP_ADDR_DATL))
				audio_data_low <= xwdata;
			if (wr_dath)
				audio_data_high <= xwdata;
			if (pend_wr && !enable && expand && !compress)
			begin
				// Standalone expansion, readable one cycle after the write.
				{audio_data_high, audio_data_low} <= exp_out;	// [RULE_09] [RULE_11] [RULE_04]
			end
			else if (pend_wr && !enable && compress)
			begin
				// Standalone compression; compression wins if both bits are set.
				audio_data_high <= cmp_out;	// [RULE_09] [RULE_11] [RULE_05] [RULE_10]
			end
			else if (rx_new && enable)
			begin
				if (compress)
					audio_data_high <= cmp_out;	// [RULE_05]
				else
					{audio_data_high, audio_data_low} <= rx_lbuf;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit hand-over: a sample is posted the cycle after the high byte write.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			tx_hold    <= 16'h0000;
			tx_req_tgl <= 1'b0;
		end
		else if (clk_en && pend_wr && enable)
		begin
			tx_hold    <= expand ? exp_out : {audio_data_high, audio_data_low};	// [RULE_04]
			tx_req_tgl <= ~tx_req_tgl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Buffer flags; a hardware set wins over a software clear in the same cycle.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			tx_empty <= 1'b1;
			rx_full  <= 1'b0;
			ack_s    <= 3'h0;
			rxt_s    <= 3'h0;
		end
		else if (clk_en)
		begin
			ack_s <= {ack_s[1:0], tx_ack_tgl};
			rxt_s <= {rxt_s[1:0], rx_tgl};
			if (fetched)
				tx_empty <= 1'b1;
			else if (wr_dath)
				tx_empty <= 1'b0;
			if (rx_new && enable)
				rx_full <= 1'b1;
			else if (rd_dath)
				rx_full <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			xrdata <= 8'h00;
		else if (clk_en && xrd)
		begin
			case (xaddr)
				ASP_ADDR_CFG0: xrdata <= audio_port_config0;
				ASP_ADDR_CFG1: xrdata <= audio_port_config1;
				ASP_ADDR_DATL: xrdata <= audio_data_low;
				ASP_ADDR_DATH: xrdata <= audio_data_high;
				ASP_ADDR_STAT: xrdata <= {6'h00, rx_full, tx_empty};
				default:       xrdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt requests, each gated by its enable bit.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end
		else if (clk_en)
		begin
			tx_irq <= enable && tx_empty && audio_port_config0[ASP_BIT_TX_IRQ_EN];	// [RULE_12]
			rx_irq <= enable && rx_full && audio_port_config0[ASP_BIT_RX_IRQ_EN];	// [RULE_12]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Master serial clock divider and pad enables.
	logic [15:0] div_cnt;	// Half period counter.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			div_cnt <= 16'h0000;
			sck_out <= 1'b0;
			sck_oe  <= 1'b0;
			ws_oe   <= 1'b0;
		end
		else if (clk_en)
		begin
			sck_oe <= enable && audio_port_config0[ASP_BIT_MASTER];	// [RULE_08]
			ws_oe  <= enable && audio_port_config0[ASP_BIT_MASTER];	// [RULE_08]
			if (!(enable && audio_port_config0[ASP_BIT_MASTER]))
			begin
				div_cnt <= 16'h0000;
				sck_out <= 1'b0;
			end
			else if (div_cnt == 16'(SCK_HALF - 1))
			begin
				div_cnt <= 16'h0000;
				sck_out <= ~sck_out;	// [RULE_08]
			end
			else
				div_cnt <= div_cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: level synchronisers for reset and configuration.
	logic [1:0] lrst_s;	// Reset release synchroniser.
	logic [1:0] len_s;	// Enable.
	logic [1:0] lms_s;	// Master.
	logic [1:0] ltm_s;	// Transmit mono.
	logic [1:0] lrm_s;	// Receive mono.
	logic [1:0] lreq_s;	// Transmit request toggle.
	logic [4:0] lwd_s1;	// Word size, first stage.
	logic [4:0] lwd_s2;	// Word size, second stage.
	always_ff @(posedge sck_in)
	begin
		lrst_s <= {lrst_s[0], resetn};
		len_s  <= {len_s[0], enable};
		lms_s  <= {lms_s[0], audio_port_config0[ASP_BIT_MASTER]};
		ltm_s  <= {ltm_s[0], audio_port_config0[ASP_BIT_TX_MONO]};
		lrm_s  <= {lrm_s[0], audio_port_config0[ASP_BIT_RX_MONO]};
		lreq_s <= {lreq_s[0], tx_req_tgl};
		lwd_s1 <= audio_port_config1[7:ASP_WORDS_LSB];
		lwd_s2 <= lwd_s1;
	end

	wire lrun = lrst_s[1] && len_s[1];	// Link logic active.

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: word select generation and channel boundary detection.
	logic [4:0]  gen_cnt;	// Bit counter for master word select.
	logic        ws_q;	// Sampled word select.
	logic        ws_prev;	// Word select one bit earlier.
	always_ff @(posedge sck_in)
	begin
		if (!lrun)
		begin
			gen_cnt <= 5'h00;
			ws_out  <= 1'b0;
			ws_q    <= 1'b0;
			ws_prev <= 1'b0;
		end
		else
		begin
			if (gen_cnt == lwd_s2)
			begin
				gen_cnt <= 5'h00;
				ws_out  <= ~ws_out;	// [RULE_08]
			end
			else
				gen_cnt <= gen_cnt + 5'h01;
			ws_q    <= lms_s[1] ? ws_out : ws_in;	// [RULE_08]
			ws_prev <= ws_q;
		end
	end

	wire start = ws_q ^ ws_prev;	// First bit of a channel word.

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: transmit fetch and shifter; zeros follow the sixteen bits.
	logic [15:0] tx_lbuf;	// Sample copied from the system domain.
	logic        req_seen;	// Last request toggle taken.
	logic [15:0] tx_cur;	// Sample of the current frame.
	logic [15:0] tx_shift;	// Outgoing bits.
	always_ff @(posedge sck_in)
	begin
		if (!lrun)
		begin
			tx_lbuf    <= 16'h0000;
			req_seen   <= 1'b0;
			tx_cur     <= 16'h0000;
			tx_shift   <= 16'h0000;
			tx_sd      <= 1'b0;
			tx_ack_tgl <= 1'b0;
		end
		else
		begin
			if (lreq_s[1] != req_seen)
			begin
				tx_lbuf  <= tx_hold;	// Stable: posted three or more edges ago.
				req_seen <= lreq_s[1];
			end
			if (start && ws_q && ltm_s[1])
			begin
				tx_sd    <= tx_cur[15];	// [RULE_06]
				tx_shift <= {tx_cur[14:0], 1'b0};
			end
			else if (start)
			begin
				tx_cur     <= tx_lbuf;
				tx_sd      <= tx_lbuf[15];
				tx_shift   <= {tx_lbuf[14:0], 1'b0};
				tx_ack_tgl <= ~tx_ack_tgl;	// [RULE_06]
			end
			else
			begin
				tx_sd    <= tx_shift[15];
				tx_shift <= {tx_shift[14:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: receive shifter; bits past sixteen are dropped.
	logic [15:0] rx_shift;	// Incoming bits, MSB first.
	logic [4:0]  rx_cnt;	// Bits taken in the current word.
	always_ff @(posedge sck_in)
	begin
		if (!lrun)
		begin
			rx_shift <= 16'h0000;
			rx_cnt   <= 5'h00;
			rx_lbuf  <= 16'h0000;
			rx_tgl   <= 1'b0;
		end
		else if (start)
		begin
			if ((rx_cnt != 5'h00) && !(ws_prev && lrm_s[1]))
			begin
				rx_lbuf <= rx_shift;	// [RULE_07]
				rx_tgl  <= ~rx_tgl;
			end
			rx_shift <= {rx_sd, 15'h0000};
			rx_cnt   <= 5'h01;
		end
		else if (rx_cnt < 5'h10)
		begin
			rx_shift[4'hF - rx_cnt[3:0]] <= rx_sd;
			rx_cnt                      <= rx_cnt + 5'h01;
		end
	end

endmodule : asp_port

//--- asp_unused_guard.sv
// This file holds no logic; the port is built from asp_port and asp_mulaw.

//--- asp_port_properties.sv
// Checker: timing and gating relations on the audio port pins.
// Assumes it is bound to asp_port and sees only its ports.
`timescale 1ns/1ps
module asp_port_checker
#(
	parameter int SCK_HALF = asp_pkg::ASP_SCK_HALF	// Master half period in ref_clk cycles.
)
(
	// Clock and bus.
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic [15:0] xaddr,
	input wire logic        xwr,
	input wire logic        xrd,
	input wire logic [7:0]  xwdata,
	input wire logic [7:0]  xrdata,
	// Interrupts and clock pad.
	input wire logic        tx_irq,
	input wire logic        rx_irq,
	input wire logic        sck_out,
	input wire logic        sck_oe
);
	import asp_pkg::*;
	logic [7:0] cfg;	// Shadow of the first config register.
	logic       sck_q;	// Last sampled master clock.
	int         hc;	// Cycles since the master clock moved.
	logic       seen;	// One master edge has been seen.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////
	// Mirror config writes exactly as the port takes them.
	always_ff @(posedge ref_clk)
		if (!resetn)
			cfg <= ASP_CFG0_RESET;
		else if (clk_en && xwr && xaddr == ASP_ADDR_CFG0)
			cfg <= xwdata;
	// Measure the spacing of master clock edges.
	always_ff @(posedge ref_clk)
	begin
		sck_q <= sck_out;
		if (!resetn || !sck_oe)
		begin
			hc   <= 0;
			seen <= 1'b0;
		end
		else if (clk_en)
		begin
			hc   <= (sck_out != sck_q) ? 0 : hc + 1;
			seen <= seen | (sck_out != sck_q);
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_quiet;
		$rose(resetn) |-> xrdata == 8'h00 && !tx_irq && !rx_irq && !sck_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
	property p_out_range;
		xrd && clk_en && (xaddr < 16'hDF40 || xaddr > 16'hDF48) |=> xrdata == 8'h00;
	endproperty
	a_out_range: assert property (p_out_range) else $error("foreign read not zero");
	property p_reserved;
		xrd && clk_en && xaddr inside {16'hDF44, 16'hDF45, 16'hDF47} |=> xrdata == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved read not zero");
	property p_cfg_read;
		xrd && clk_en && xaddr == ASP_ADDR_CFG0 |=> xrdata == $past(cfg);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback off");
	property p_hold;
		!(xrd && clk_en) |=> $stable(xrdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_tx_gate;
		clk_en && !(cfg[7] && cfg[0]) |=> !tx_irq;
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx request not gated");
	property p_rx_gate;
		clk_en && !(cfg[6] && cfg[0]) |=> !rx_irq;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx request not gated");
	property p_slave;
		clk_en && !cfg[1] |=> !sck_oe;
	endproperty
	a_slave: assert property (p_slave) else $error("slave drives clock");
	property p_half;
		clk_en && seen && sck_oe && sck_out != sck_q |-> hc == SCK_HALF - 1;
	endproperty
	a_half: assert property (p_half) else $error("master clock period off");
	c_cfg: cover property (xrd && xaddr == ASP_ADDR_CFG0);
	c_tx: cover property ($rose(tx_irq));
	c_master: cover property ($rose(sck_oe));
endmodule : asp_port_checker
bind asp_port asp_port_checker #(.SCK_HALF(SCK_HALF)) asp_port_checker_inst (
	.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .xaddr(xaddr),
	.xwr(xwr), .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata), .tx_irq(tx_irq),
	.rx_irq(rx_irq), .sck_out(sck_out), .sck_oe(sck_oe));

//--- asp_codec_model.sv
// Partner: external stereo master that clocks one frame per request.
// Assumes the port is in slave mode while a frame runs.
`timescale 1ns/1ps
module asp_codec_model
(
	// Frame request and its words.
	input  wire logic        go,
	input  wire logic [15:0] left,
	input  wire logic [15:0] right,
	// Pins.
	input  wire logic        tx_sd,
	output logic             sck,
	output logic             ws,
	output logic             sd,
	// Bits heard from the port, last edge in bit 0.
	output logic             done,
	output logic      [63:0] heard
);
	logic [63:0] bits;	// Dummy right, left, right, pad left.
	int          k;	// Word index of the next bit.
	// Clock stands low between frames; data shows the inverse once released.
	initial
	begin
		sck = 1'b0;
		ws = 1'b0;
		sd = 1'b0;
		done = 1'b0;
		heard = '0;
		forever
		begin
			@(posedge go);
			done = 1'b0;
			bits = {16'hA5C3, left, right, 16'h0000};
			#3.3;
			for (int j = -8; j < 64; j++)
			begin
				k = (j + 1) / 16;
				ws = (j >= -1) && (k < 3) && !k[0];
				sd = (j >= 0) ? bits[63 - j] : 1'b0;
				#7.5;
				if (j >= 0)
					heard = {heard[62:0], tx_sd};
				sck = 1'b1;
				#7.5;
				sck = 1'b0;
			end
			sd = ~sd;
			done = 1'b1;
		end
	end
endmodule : asp_codec_model

//--- testbench.sv
// Testbench: registers, stand-alone codec, slave link and master clock.
// Assumes the port is the only device on the byte bus.
`timescale 1ns/1ps
module testbench;
	import asp_pkg::*;
	localparam int HALF = 4;	// Short master half period.
	logic        ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, xwr = 1'b0, xrd = 1'b0;
	logic [15:0] xaddr = '0, left = '0, right = '0;
	logic [7:0]  xwdata = '0, xrdata;
	logic        tx_irq, rx_irq, sck_out, sck_oe, ws_out, ws_oe, tx_sd, go = 1'b0;
	logic        p_sck, p_ws, p_sd, done;
	logic [63:0] heard;
	int          errors = 0, checks_done = 0;
	logic [15:0] ra [9] = '{16'hDF40, 16'hDF41, 16'hDF42, 16'hDF43, 16'hDF46,
		16'hDF44, 16'hDF48, 16'hDF3F, 16'hDF49};
	logic [7:0]  rv [9] = '{8'h00, 8'h78, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  cfgs [3] = '{8'h81, 8'hCD, 8'hB1};
	always #4 ref_clk = ~ref_clk;
	asp_port #(.SCK_HALF(HALF)) asp_port_inst (.ref_clk(ref_clk), .resetn(resetn),
		.clk_en(clk_en), .xaddr(xaddr), .xwr(xwr), .xrd(xrd), .xwdata(xwdata),
		.xrdata(xrdata), .tx_irq(tx_irq), .rx_irq(rx_irq),
		.sck_in(sck_oe ? sck_out : p_sck), .sck_out(sck_out), .sck_oe(sck_oe),
		.ws_in(ws_oe ? ws_out : p_ws), .ws_out(ws_out), .ws_oe(ws_oe),
		.rx_sd(p_sd), .tx_sd(tx_sd));
	asp_codec_model asp_codec_model_inst (.go(go), .left(left), .right(right),
		.tx_sd(tx_sd), .sck(p_sck), .ws(p_ws), .sd(p_sd), .done(done), .heard(heard));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] ulaw_exp(input logic [7:0] u);
		logic [7:0] v;
		int         t;
		v = ~u;
		t = (int'(v[3:0]) * 8 + 132) << v[6:4];
		return v[7] ? 16'(132 - t) : 16'(t - 132);
	endfunction : ulaw_exp
	function automatic logic [7:0] ulaw_cmp(input logic [15:0] s);
		int         p;
		int         seg;
		logic [7:0] m;
		p = $signed(s);
		m = 8'hFF;
		seg = 0;
		if (p < 0)
		begin
			p = -p;
			m = 8'h7F;
		end
		if (p > 32635)
			p = 32635;
		p = p + 132;
		while (seg < 7 && p > (256 << seg) - 1)
			seg++;
		return 8'((seg << 4) | ((p >> (seg + 3)) & 15)) ^ m;
	endfunction : ulaw_cmp
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: byte %h, want %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: word %h, want %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		xaddr = a;
		xwdata = d;
		xwr = 1'b1;
		@(posedge ref_clk);
		#1 xwr = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		xaddr = a;
		xrd = 1'b1;
		@(posedge ref_clk);
		#1 xrd = 1'b0;
		d = xrdata;
		@(posedge ref_clk);
		#1;
	endtask : rd
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole run needs about seven microseconds.
	initial
	begin
		#100000;
		errors++;
		stop_test();
	end
	// Main sequence.
	initial
	begin
		logic [7:0]  b, c, d, cf;
		logic [15:0] w;
		logic [15:0] s [2];
		int          n;
		void'($urandom(32'h3751));
		repeat (5) @(posedge ref_clk);
		#1 resetn = 1'b1;
		foreach (ra[i])
		begin
			rd(ra[i], b);
			chk_byte(b, rv[i]);
		end
		b = 8'($urandom) & 8'hCE;
		wr(ASP_ADDR_CFG0, b);
		rd(ASP_ADDR_CFG0, c);
		chk_byte(c, b);
		clk_en = 1'b0;
		wr(ASP_ADDR_CFG0, 8'hFF);
		clk_en = 1'b1;
		wr(16'hDF44, 8'($urandom));
		rd(ASP_ADDR_CFG0, c);
		chk_byte(c, b);
		rd(16'hDF44, c);
		chk_byte(c, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 12; i++)
		begin
			b = (i == 0) ? 8'hFF : 8'($urandom);
			w = (i == 0) ? 16'h8000 : 16'($urandom);
			wr(ASP_ADDR_CFG0, 8'h20);
			wr(ASP_ADDR_DATH, b);
			rd(ASP_ADDR_DATH, c);
			rd(ASP_ADDR_DATL, d);
			chk_word({c, d}, ulaw_exp(b));
			wr(ASP_ADDR_CFG0, 8'h10);
			wr(ASP_ADDR_DATL, w[7:0]);
			wr(ASP_ADDR_DATH, w[15:8]);
			rd(ASP_ADDR_DATH, c);
			chk_byte(c, ulaw_cmp(w));
		end
		$display("test codec done");
		go = 1'b1;	// Idle frame while disabled clears the link logic.
		for (n = 0; done !== 1'b1 && n < 2000; n++)
			@(posedge ref_clk);
		#1 go = 1'b0;
		chk_byte({7'h00, done}, 8'h01);
		for (int m = 0; m < 3; m++)
		begin
			cf = cfgs[m];
			wr(ASP_ADDR_CFG0, cf);
			s[0] = 16'($urandom);
			s[1] = 16'($urandom);
			left = 16'($urandom);
			right = 16'($urandom);
			wr(ASP_ADDR_DATL, 8'h11);
			wr(ASP_ADDR_DATH, 8'h22);
			go = 1'b1;
			// Mono fetches at left starts only, so one new sample fills the frame.
			for (int k = 0; k < (cf[3] ? 1 : 2); k++)
			begin
				for (n = 0; tx_irq !== 1'b1 && n < 500; n++)
					@(posedge ref_clk);
				#1;
				chk_byte({7'h00, tx_irq}, 8'h01);
				wr(ASP_ADDR_DATL, s[k][7:0]);
				wr(ASP_ADDR_DATH, s[k][15:8]);
			end
			for (n = 0; done !== 1'b1 && n < 2000; n++)
				@(posedge ref_clk);
			#1 go = 1'b0;
			chk_byte({7'h00, done}, 8'h01);
			// In mono the left slot carries the sample posted before the frame.
			w = cf[3] ? 16'h2211 : s[0];
			w = cf[5] ? ulaw_exp(w[15:8]) : w;
			chk_word(heard[46:31], w);
			if (!cf[3])
				w = cf[5] ? ulaw_exp(s[1][15:8]) : s[1];
			chk_word(heard[30:15], w);
			chk_byte({7'h00, rx_irq}, {7'h00, cf[6]});
			rd(ASP_ADDR_DATH, c);
			rd(ASP_ADDR_DATL, d);
			w = cf[2] ? left : right;
			if (cf[4])
				chk_byte(c, ulaw_cmp(w));
			else
				chk_word({c, d}, w);
			chk_byte({7'h00, rx_irq}, 8'h00);
		end
		$display("test link done");
		wr(ASP_ADDR_CFG0, 8'h03);
		repeat (20 * HALF) @(posedge ref_clk);
		#1;
		chk_byte({6'h00, ws_oe, sck_oe}, 8'h03);
		wr(ASP_ADDR_CFG0, 8'h00);
		chk_byte({7'h00, sck_oe}, 8'h00);
		$display("test master done");
		stop_test();
	end
endmodule : testbench
